/* pkg/ujt_pkg.sv */
// Shared constants and types for the user scan access bridge.
// Assumes a single system clock that samples all JTAG pins.
package ujt_pkg;

    // ------------------------------------------------------------
    // Widths and instruction ranges
    // ------------------------------------------------------------
    localparam int IR_WIDTH = 8;
    localparam int DR_WIDTH = 32;
    localparam logic [7:0] USER_IR_LO = 8'h10;
    localparam logic [7:0] USER_IR_HI = 8'h7f;
    localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;
    localparam logic [7:0] INSTR_IDCODE = 8'h0f;
    localparam logic [7:0] INSTR_BYPASS = 8'hff;
    localparam logic [7:0] IR_RESET_VAL = 8'h0f;
    localparam logic [31:0] DR_RESET_VAL = 32'h00000000;
    localparam logic [2:0] TMS_ONES_TO_RESET = 3'h5;

    // ------------------------------------------------------------
    // TAP controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET      = 4'b0000,
        TAP_IDLE       = 4'b0001,
        TAP_SEL_DR     = 4'b0010,
        TAP_CAPTURE_DR = 4'b0011,
        TAP_SHIFT_DR   = 4'b0100,
        TAP_EXIT1_DR   = 4'b0101,
        TAP_PAUSE_DR   = 4'b0110,
        TAP_EXIT2_DR   = 4'b0111,
        TAP_UPDATE_DR  = 4'b1000,
        TAP_SEL_IR     = 4'b1001,
        TAP_CAPTURE_IR = 4'b1010,
        TAP_SHIFT_IR   = 4'b1011,
        TAP_EXIT1_IR   = 4'b1100,
        TAP_PAUSE_IR   = 4'b1101,
        TAP_EXIT2_IR   = 4'b1110,
        TAP_UPDATE_IR  = 4'b1111
    } ujt_tap_state_e;

endpackage

/* core/ujt_sync_bit.sv */
// Two-flop synchroniser for one pin input.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/100ps
module ujt_sync_bit #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Data
    input wire logic async_in,
    output logic sync_out
);

    logic meta_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // ujt_sync_bit

/* core/ujt_tap_bridge.sv */
// TAP controller with user scan access for fabric logic.
// Assumes TCK runs far slower than clk_sys, which samples every pin.
//
// How it works
// [R1] Instruction register shown on user_ir_value.
// [R2] Codes 16 to 127 are user instructions.
// [R3] user_tap_reset_n low only in reset state.
// [R4] System reset forces the TAP into reset.
// [R5] TDI pin goes straight to user_tdi.
// [R6] User codes route user_tdo onto TDO.
// [R7] user_dr_shift high only in Shift-DR.
// [R8] user_dr_capture high only in Capture-DR.
// [R9] user_dr_update high only in Update-DR.
// [R10] TCK pin goes straight to user_dr_clock.
// [R11] Low test reset puts TAP in reset.
// [R12] Pins connect to top-level design ports.
// [R13] TDO serial out, TDI serial in.
// [R14] Standard sixteen-state TAP stepped by TCK.
// [R15] Other codes drive TDO from internal registers.
`timescale 1ns/100ps
module ujt_tap_bridge
    import ujt_pkg::*;
#(
    // Identification word, value arbitrary.
    parameter logic [31:0] ID_WORD = 32'h00000001
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // JTAG pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic test_reset_n,
    output logic tdo,
    output logic tdo_oe,
    // User fabric side
    output logic [7:0] user_ir_value,
    output logic user_tap_reset_n,
    output logic user_tdi,
    input wire logic user_tdo,
    output logic user_dr_shift,
    output logic user_dr_capture,
    output logic user_dr_update,
    output logic user_dr_clock
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic trst_n_s;
    logic user_tdo_s;

    ujt_sync_bit #(.RESET_VAL(1'b0)) u_sync_tck (
        .clk_sys(clk_sys), .reset_n(reset_n), .async_in(tck), .sync_out(tck_s));
    ujt_sync_bit #(.RESET_VAL(1'b1)) u_sync_tms (
        .clk_sys(clk_sys), .reset_n(reset_n), .async_in(tms), .sync_out(tms_s));
    ujt_sync_bit #(.RESET_VAL(1'b1)) u_sync_tdi (
        .clk_sys(clk_sys), .reset_n(reset_n), .async_in(tdi), .sync_out(tdi_s));
    ujt_sync_bit #(.RESET_VAL(1'b0)) u_sync_trst (
        .clk_sys(clk_sys), .reset_n(reset_n), .async_in(test_reset_n),
        .sync_out(trst_n_s));
    ujt_sync_bit #(.RESET_VAL(1'b0)) u_sync_user_tdo (
        .clk_sys(clk_sys), .reset_n(reset_n), .async_in(user_tdo),
        .sync_out(user_tdo_s));

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    ujt_tap_state_e state_reg;
    ujt_tap_state_e state_next;
    logic tck_d_reg;
    logic [7:0] ir_shift_reg;
    logic [7:0] ir_reg;
    logic [31:0] dr_shift_reg;
    logic tdo_reg;
    logic tdo_oe_reg;
    logic [2:0] tms_ones_reg;

    wire tck_rise = tck_s & ~tck_d_reg;
    wire tck_fall = ~tck_s & tck_d_reg;
    wire user_range = (ir_reg >= USER_IR_LO) && (ir_reg <= USER_IR_HI); // [R2]
    wire sel_idcode = (ir_reg == INSTR_IDCODE);
    wire in_shift_ir = (state_reg == TAP_SHIFT_IR);
    wire in_shift_dr = (state_reg == TAP_SHIFT_DR);
    wire tdo_internal = in_shift_ir ? ir_shift_reg[0] : dr_shift_reg[0]; // [R15]
    wire tdo_select = (in_shift_dr && user_range) ? user_tdo_s : tdo_internal; // [R6]

    // ------------------------------------------------------------
    // TAP next-state
    // ------------------------------------------------------------
    always_comb begin // [R14]
        state_next = state_reg;
        case (state_reg)
            TAP_RESET: state_next = tms_s ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_next = tms_s ? TAP_SEL_IR : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: state_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_next = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_next = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_next = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_next = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR: state_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_next = tms_s ? TAP_RESET : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: state_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_next = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_next = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_next = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_next = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR: state_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
            default: state_next = TAP_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // TAP state and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !trst_n_s) begin // [R4] [R11]
            state_reg <= TAP_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next; // [R14]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tck_d_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_s;
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_reg == TAP_RESET) begin
            ir_shift_reg <= IR_RESET_VAL;
            ir_reg <= IR_RESET_VAL;
        end else if (tck_rise) begin
            if (state_reg == TAP_CAPTURE_IR) begin
                ir_shift_reg <= IR_CAPTURE_VAL;
            end else if (in_shift_ir) begin
                ir_shift_reg <= {tdi_s, ir_shift_reg[7:1]}; // [R13]
            end else if (state_reg == TAP_UPDATE_IR) begin
                ir_reg <= ir_shift_reg; // [R1]
            end
        end
    end

    // ------------------------------------------------------------
    // Internal data registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dr_shift_reg <= DR_RESET_VAL;
        end else if (tck_rise && state_reg == TAP_CAPTURE_DR) begin
            dr_shift_reg <= sel_idcode ? ID_WORD : DR_RESET_VAL;
        end else if (tck_rise && in_shift_dr) begin
            dr_shift_reg <= sel_idcode ? {tdi_s, dr_shift_reg[31:1]} : {31'h0, tdi_s};
        end
    end

    // ------------------------------------------------------------
    // TDO on the falling TCK edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg <= tdo_select; // [R6] [R15] [R13]
            tdo_oe_reg <= in_shift_ir | in_shift_dr;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tdo = tdo_reg;
    assign tdo_oe = tdo_oe_reg;
    assign user_ir_value = ir_reg; // [R1]
    assign user_tap_reset_n = (state_reg != TAP_RESET); // [R3]
    assign user_tdi = tdi; // [R5]
    assign user_dr_clock = tck; // [R10]
    assign user_dr_shift = in_shift_dr; // [R7]
    assign user_dr_capture = (state_reg == TAP_CAPTURE_DR); // [R8]
    assign user_dr_update = (state_reg == TAP_UPDATE_DR); // [R9]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !trst_n_s) begin
            tms_ones_reg <= 3'h0;
        end else if (tck_rise) begin
            tms_ones_reg <= !tms_s ? 3'h0 :
                (tms_ones_reg == TMS_ONES_TO_RESET) ? tms_ones_reg : tms_ones_reg + 3'h1;
        end
    end

    sequence s_enter_shift_dr;
        tck_rise && state_reg == TAP_CAPTURE_DR && !tms_s;
    endsequence

    sequence s_enter_capture_dr;
        tck_rise && state_reg == TAP_SEL_DR && !tms_s;
    endsequence

    sequence s_enter_update_dr;
        tck_rise && state_reg == TAP_EXIT1_DR && tms_s;
    endsequence

    a_shift_strobe: assert property (@(posedge clk_sys) disable iff (!reset_n || !trst_n_s) // [R7]
        s_enter_shift_dr |=> user_dr_shift && !user_dr_capture ##1 user_dr_shift)
        else $error("shift strobe missing after capture");
    a_capture_strobe: assert property (@(posedge clk_sys) // [R8]
        disable iff (!reset_n || !trst_n_s)
        s_enter_capture_dr |=> user_dr_capture && !user_dr_shift && !user_dr_update)
        else $error("capture strobe missing");
    a_update_strobe: assert property (@(posedge clk_sys) // [R9]
        disable iff (!reset_n || !trst_n_s)
        s_enter_update_dr |=> user_dr_update && !user_dr_shift)
        else $error("update strobe missing");
    a_tap_reset_flag: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R3]
        tck_rise && state_reg == TAP_SEL_IR && tms_s |=> !user_tap_reset_n)
        else $error("reset flag not low in reset state");
    a_power_on_reset: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R4]
        $rose(reset_n) |-> !user_tap_reset_n && user_ir_value == IR_RESET_VAL)
        else $error("TAP not in reset after system reset");
    a_test_reset_pin: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R11]
        !trst_n_s |=> !user_tap_reset_n)
        else $error("test reset did not reset TAP");
    a_five_ones: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R14]
        tms_ones_reg == TMS_ONES_TO_RESET |-> !user_tap_reset_n)
        else $error("five TMS ones did not reach reset");
    a_ir_update: assert property (@(posedge clk_sys) disable iff (!reset_n || !trst_n_s) // [R1]
        tck_rise && state_reg == TAP_UPDATE_IR |=> user_ir_value == $past(ir_shift_reg))
        else $error("IR not presented after update");
    a_user_tdo_route: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R6]
        tck_fall && in_shift_dr && user_range |=> tdo == $past(user_tdo_s) && tdo_oe)
        else $error("user data not on TDO");
    a_internal_tdo: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R15]
        tck_fall && in_shift_dr && !user_range |=> tdo == $past(dr_shift_reg[0]))
        else $error("internal data not on TDO");
    a_ir_tdo: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R13]
        tck_fall && in_shift_ir |=> tdo == $past(ir_shift_reg[0]) && tdo_oe)
        else $error("IR bit not on TDO");
    a_pass_through: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R5] [R10]
        user_tdi == tdi && user_dr_clock == tck)
        else $error("pin pass-through broken");

endmodule // ujt_tap_bridge

/* test/ujt_user_model.sv */
// User fabric logic beside the scan bridge: one 32-bit user data register.
// Assumes user_dr_clock is the raw test clock and the strobes are stable at its rising edge.
`timescale 1ns/100ps
module ujt_user_model
    import ujt_pkg::*;
#(
    parameter logic [31:0] CAPTURE_WORD = 32'h5a3c96e1
) (
    // Bridge outputs
    input wire logic [7:0] user_ir_value,
    input wire logic user_tap_reset_n,
    input wire logic user_tdi,
    input wire logic user_dr_shift,
    input wire logic user_dr_capture,
    input wire logic user_dr_update,
    input wire logic user_dr_clock,
    // Bridge inputs and observation
    output logic user_tdo,
    output logic [31:0] update_word
);
    // ------------------------------------------------------------
    // User data register
    // ------------------------------------------------------------
    logic [31:0] shift_reg;
    wire user_sel = (user_ir_value >= USER_IR_LO) && (user_ir_value <= USER_IR_HI);

    assign user_tdo = shift_reg[0];

    always_ff @(posedge user_dr_clock or negedge user_tap_reset_n) begin
        if (!user_tap_reset_n) begin
            shift_reg <= 32'h00000000;
            update_word <= 32'h00000000;
        end else if (user_sel && user_dr_capture) begin
            shift_reg <= CAPTURE_WORD;
        end else if (user_sel && user_dr_shift) begin
            shift_reg <= {user_tdi, shift_reg[31:1]};
        end else if (user_sel && user_dr_update) begin
            update_word <= shift_reg;
        end
    end
endmodule // ujt_user_model

/* test/test_ujt_tap_bridge.sv */
// Self-checking bench for the scan bridge, acting as the external test host.
// Assumes a 100 MHz system clock and a 160 ns test clock made by the host.
`timescale 1ns/100ps
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module test_ujt_tap_bridge;
    import ujt_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [31:0] ID_VAL = 32'h00004c5b; // Arbitrary identification value.
    localparam logic [31:0] USER_WORD = 32'h5a3c96e1;
    localparam logic [31:0] DIN = 32'h9ac35e71;
    logic clk_sys, reset_n, tck, tms, tdi, test_reset_n, tdo, tdo_oe, user_tap_reset_n;
    logic user_tdi, user_tdo, user_dr_shift, user_dr_capture, user_dr_update, user_dr_clock;
    logic [7:0] user_ir_value;
    logic [31:0] upd_word, dout;
    logic last_tdo, last_oe;
    int errors = 0;
    int n_compared = 0;

    ujt_tap_bridge #(.ID_WORD(ID_VAL)) i_ujt_tap_bridge (
        .clk_sys(clk_sys), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .test_reset_n(test_reset_n), .tdo(tdo), .tdo_oe(tdo_oe),
        .user_ir_value(user_ir_value), .user_tap_reset_n(user_tap_reset_n),
        .user_tdi(user_tdi), .user_tdo(user_tdo), .user_dr_shift(user_dr_shift),
        .user_dr_capture(user_dr_capture), .user_dr_update(user_dr_update),
        .user_dr_clock(user_dr_clock));
    ujt_user_model #(.CAPTURE_WORD(USER_WORD)) i_ujt_user_model (
        .user_ir_value(user_ir_value), .user_tap_reset_n(user_tap_reset_n),
        .user_tdi(user_tdi), .user_dr_shift(user_dr_shift),
        .user_dr_capture(user_dr_capture), .user_dr_update(user_dr_update),
        .user_dr_clock(user_dr_clock), .user_tdo(user_tdo), .update_word(upd_word));

    always #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // One test clock period; TDO is taken just before the rising edge.
    task automatic tck_cycle(input logic tms_v, input logic tdi_v);
        tms = tms_v;
        tdi = tdi_v;
        step(8);
        `CHK("user_tdi", tdi, user_tdi);
        `CHK("dr_clock_low", 1'b0, user_dr_clock);
        last_tdo = tdo;
        last_oe = tdo_oe;
        tck = 1'b1;
        step(8);
        `CHK("dr_clock_high", 1'b1, user_dr_clock);
        tck = 1'b0;
    endtask
    // Full IR or DR scan from idle back to idle, LSB first.
    task automatic scan(input logic ir, input int n, input logic [31:0] din);
        dout = 32'h00000000;
        tck_cycle(1'b1, 1'b0);
        if (ir) tck_cycle(1'b1, 1'b0);
        tck_cycle(1'b0, 1'b0);
        `CHK("capture", !ir, user_dr_capture);
        tck_cycle(1'b0, 1'b0);
        `CHK("shift", !ir, user_dr_shift);
        for (int i = 0; i < n; i++) begin
            tck_cycle(i == n - 1, din[i]);
            dout[i] = last_tdo;
            `CHK("tdo_oe", 1'b1, last_oe);
        end
        `CHK("shift_off", 1'b0, user_dr_shift);
        tck_cycle(1'b1, 1'b0);
        `CHK("tdo_oe_off", 1'b0, last_oe);
        `CHK("update", !ir, user_dr_update);
        `CHK("capture_off", 1'b0, user_dr_capture);
        tck_cycle(1'b0, 1'b0);
        `CHK("update_off", 1'b0, user_dr_update);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHK("por_rst", 1'b0, user_tap_reset_n);
        `CHK("por_ir", IR_RESET_VAL, user_ir_value);
        `CHK("por_strobes", 3'b000, {user_dr_shift, user_dr_capture, user_dr_update});
        tck_cycle(1'b1, 1'b1);
        `CHK("stay_rst", 1'b0, user_tap_reset_n);
        tck_cycle(1'b0, 1'b0);
        `CHK("idle_rst", 1'b1, user_tap_reset_n);
    endtask
    task automatic t_codes();
        logic [7:0] codes [4] = '{8'h0f, 8'h10, 8'h7f, 8'h80};
        foreach (codes[k]) begin
            scan(1'b1, 8, {24'h000000, codes[k]});
            `CHK("ir_capture", IR_CAPTURE_VAL, dout[7:0]);
            `CHK("ir_value", codes[k], user_ir_value);
            scan(1'b0, 32, DIN);
            if (codes[k] >= USER_IR_LO && codes[k] <= USER_IR_HI) begin
                `CHK("user_data", USER_WORD, dout);
                `CHK("user_shift_in", DIN, upd_word);
            end else if (codes[k] == INSTR_IDCODE) begin
                `CHK("idcode", ID_VAL, dout);
            end else begin
                `CHK("bypass", {DIN[30:0], 1'b0}, dout);
            end
        end
    endtask
    task automatic t_trst();
        test_reset_n = 1'b0;
        step(5);
        `CHK("trst_rst", 1'b0, user_tap_reset_n);
        `CHK("trst_ir", IR_RESET_VAL, user_ir_value);
        test_reset_n = 1'b1;
        step(4);
        tck_cycle(1'b0, 1'b1);
        `CHK("trst_idle", 1'b1, user_tap_reset_n);
    endtask
    task automatic t_tms_reset();
        tck_cycle(1'b1, 1'b0);
        tck_cycle(1'b0, 1'b0);
        tck_cycle(1'b0, 1'b0);
        for (int i = 0; i < 4; i++) tck_cycle(1'b1, 1'b0);
        `CHK("four_ones", 1'b1, user_tap_reset_n);
        tck_cycle(1'b1, 1'b0);
        `CHK("five_ones", 1'b0, user_tap_reset_n);
        tck_cycle(1'b0, 1'b0);
    endtask
    task automatic t_sysreset();
        reset_n = 1'b0;
        step(3);
        `CHK("sys_rst", 1'b0, user_tap_reset_n);
        reset_n = 1'b1;
        step(1);
        `CHK("sys_rst_after", 1'b0, user_tap_reset_n);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        test_reset_n = 1'b1;
        step(3);
        reset_n = 1'b1;
        step(1);
        t_reset();
        t_codes();
        t_trst();
        t_tms_reset();
        t_sysreset();
        results();
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        errors++;
        $display("MISMATCH watchdog expected done seen hang");
        results();
    end
endmodule // test_ujt_tap_bridge
